// ==== rxs_cfg.svh ====
// Constants for the receive status and receiver control block.
// Assumes inclusion by bare name; definitions only.
`ifndef RXS_CFG_SVH
`define RXS_CFG_SVH

// Status word bit positions
`define RXS_BIT_RSVD31    31
`define RXS_BIT_FILT_FAIL 30
`define RXS_LEN_MSB       29
`define RXS_LEN_LSB       16
`define RXS_BIT_SUMMARY   15
`define RXS_BIT_RSVD14    14
`define RXS_BIT_BCAST     13
`define RXS_BIT_LEN_MIS   12
`define RXS_BIT_RUNT      11
`define RXS_BIT_MCAST     10
`define RXS_BIT_RSVD9     9
`define RXS_BIT_RSVD8     8
`define RXS_BIT_TOO_LONG  7
`define RXS_BIT_LATE_COL  6
`define RXS_BIT_FTYPE     5
`define RXS_BIT_WDOG      4
`define RXS_BIT_MII_ERR   3
`define RXS_BIT_DRIBBLE   2
`define RXS_BIT_CRC       1
`define RXS_BIT_RSVD0     0

// Reset value of the status word register
`define RXS_WORD_RESET    32'h0000_0000

// Frame length limits in bytes
`define RXS_COLL_WINDOW   14'h0040
`define RXS_MAX_FRAME     14'h05EE
`define RXS_MAX_LEN_TYPE  16'h05DC
`define RXS_MIN_HEADER    14'h000E
`define RXS_FRAME_OVHD    14'h0012
`define RXS_MIN_PAYLOAD   16'h002E
`define RXS_WDOG_BYTES    14'h0800
`define RXS_DA_BYTES      14'h0006
`define RXS_LT_HI_IDX     14'h000C
`define RXS_LT_LO_IDX     14'h000D

// Dribble thresholds per operating mode
`define RXS_DRIB_MII      3'h4
`define RXS_DRIB_10M      3'h3

`endif

// ==== rxs_pkg.sv ====
// Types shared by the receive status and receiver control block.
// Assumes nothing of its surroundings.
package rxs_pkg;

	// Receive sequence states
	typedef enum logic [2:0]
	{
		st_idle,
		st_recv,
		st_wait,
		st_stop
	} rx_state_t;

	// Frame byte count
	typedef logic [13:0] byte_count_t;

endpackage : rxs_pkg

// ==== rx_frame_tracker.sv ====
// Per-frame byte counter, address class capture, length/type capture, watchdog.
// Assumes byte strobes on clk from the MAC layer; start pulse precedes first byte.
`timescale 1ns/100ps
`include "rxs_cfg.svh"

module rx_frame_tracker
	import rxs_pkg::*;
#(
	parameter byte_count_t WDOG_BYTES = `RXS_WDOG_BYTES
)
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        frame_start,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	output byte_count_t      byte_count,
	output logic             da_bcast,
	output logic             da_group,
	output logic [15:0]      len_type,
	output logic             wdog_expired
);

	byte_count_t next_byte_count;
	logic        next_da_bcast;
	logic        next_da_group;
	logic [15:0] next_len_type;
	logic        next_wdog_expired;

	// Next values of the frame trackers
	always_comb
	begin
		next_byte_count   = byte_count;
		next_da_bcast     = da_bcast;
		next_da_group     = da_group;
		next_len_type     = len_type;
		next_wdog_expired = wdog_expired;
		if (frame_start)
		begin
			next_byte_count   = 14'h0000;
			next_da_bcast     = 1'b1;
			next_da_group     = 1'b0;
			next_len_type     = 16'h0000;
			next_wdog_expired = 1'b0;
		end
		else if (byte_valid)
		begin
			// Count saturates, frame is never cut short
			if (byte_count != 14'h3FFF)
				next_byte_count = byte_count + 14'h0001;
			if (byte_count < `RXS_DA_BYTES && byte_data != 8'hFF)
				next_da_bcast = 1'b0;
			if (byte_count == 14'h0000)
				next_da_group = byte_data[0];
			if (byte_count == `RXS_LT_HI_IDX)
				next_len_type[15:8] = byte_data;
			if (byte_count == `RXS_LT_LO_IDX)
				next_len_type[7:0] = byte_data;
			if (byte_count >= WDOG_BYTES)
				next_wdog_expired = 1'b1;
		end
	end

	// Tracker registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			byte_count   <= 14'h0000;
			da_bcast     <= 1'b0;
			da_group     <= 1'b0;
			len_type     <= 16'h0000;
			wdog_expired <= 1'b0;
		end
		else
		begin
			byte_count   <= next_byte_count;
			da_bcast     <= next_da_bcast;
			da_group     <= next_da_group;
			len_type     <= next_len_type;
			wdog_expired <= next_wdog_expired;
		end
	end

endmodule : rx_frame_tracker

// ==== rx_status_ctrl.sv ====
// Receive status word builder and receiver stop/start and error control.
// Assumes MAC layer byte stream, FIFO flags and control bits all on clk.
`timescale 1ns/100ps
`include "rxs_cfg.svh"

module rx_status_ctrl
	import rxs_pkg::*;
#(
	parameter byte_count_t WDOG_BYTES = `RXS_WDOG_BYTES
)
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        receive_enable,
	input  wire logic        pass_bad_frames,
	input  wire logic        speed_10m,
	input  wire logic        frame_start,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	input  wire logic        mii_rx_er,
	input  wire logic        collision,
	input  wire logic        frame_end,
	input  wire logic        crc_ok,
	input  wire logic [2:0]  dribble_bits,
	input  wire logic        filter_fail,
	input  wire logic        data_load_done,
	input  wire logic        stat_fifo_full,
	input  wire logic        host_data_rd,
	input  wire logic        data_fifo_empty,
	input  wire logic        host_stat_rd,
	input  wire logic        stat_fifo_empty,
	input  wire logic        rxe_clear,
	output logic             stat_push,
	output logic [31:0]      stat_word,
	output logic             frame_drop,
	output logic             receiver_error_flag,
	output logic             receive_stopped_irq,
	output logic             rx_halted
);

	rx_state_t   state;
	rx_state_t   next_state;
	logic [31:0] word;
	logic [31:0] next_word;
	logic        rx_er_seen;
	logic        next_rx_er_seen;
	logic        late_col;
	logic        next_late_col;
	logic        next_stat_push;
	logic [31:0] next_stat_word;
	logic        next_frame_drop;
	logic        next_error_flag;
	logic        next_stopped_irq;
	logic        next_rx_halted;
	logic        start_ok;
	logic        count_en;
	logic        overrun;
	byte_count_t byte_count;
	logic        da_bcast;
	logic        da_group;
	logic [15:0] len_type;
	logic        wdog_expired;

	// New frames only accepted while idle and enabled
	assign start_ok = (state == st_idle) && receive_enable && frame_start;
	assign count_en = (state == st_recv) && byte_valid;

	// Byte counting and header capture
	rx_frame_tracker #(
		.WDOG_BYTES   (WDOG_BYTES)
	) u_tracker (
		.clk          (clk),
		.nrst         (nrst),
		.frame_start  (start_ok),
		.byte_valid   (count_en),
		.byte_data    (byte_data),
		.byte_count   (byte_count),
		.da_bcast     (da_bcast),
		.da_group     (da_group),
		.len_type     (len_type),
		.wdog_expired (wdog_expired)
	);

	// Build the status word from the finished frame
	function automatic logic [31:0] build_word
	(
		input byte_count_t cnt,
		input logic        ffail,
		input logic        bc,
		input logic        grp,
		input logic [15:0] lt,
		input logic        wd,
		input logic        rxer,
		input logic        lcol,
		input logic        crc_good,
		input logic [2:0]  drib,
		input logic        slow
	);
		logic [31:0] w;
		logic [15:0] pay;
		logic        runt;
		w    = 32'h0000_0000;
		pay  = {2'b00, cnt - `RXS_FRAME_OVHD};
		runt = cnt < `RXS_COLL_WINDOW;
		w[`RXS_BIT_FILT_FAIL] = ffail;
		w[`RXS_LEN_MSB:`RXS_LEN_LSB] = cnt;
		w[`RXS_BIT_BCAST] = bc;
		w[`RXS_BIT_MCAST] = grp && !bc;
		// length mismatch, padded minimum frames tolerated
		w[`RXS_BIT_LEN_MIS] = (cnt >= `RXS_MIN_HEADER) && (lt <= `RXS_MAX_LEN_TYPE)
			&& (cnt >= `RXS_FRAME_OVHD) && (lt != pay)
			&& !((lt < `RXS_MIN_PAYLOAD) && (cnt == `RXS_COLL_WINDOW));
		w[`RXS_BIT_RUNT] = runt;
		w[`RXS_BIT_TOO_LONG] = cnt > `RXS_MAX_FRAME;
		w[`RXS_BIT_LATE_COL] = lcol;
		// frame type, never under header size
		w[`RXS_BIT_FTYPE] = (cnt >= `RXS_MIN_HEADER) && (lt > `RXS_MAX_LEN_TYPE);
		w[`RXS_BIT_WDOG] = wd;
		w[`RXS_BIT_MII_ERR] = rxer;
		w[`RXS_BIT_DRIBBLE] = !lcol && (slow ? (drib >= `RXS_DRIB_10M)
			: (drib == `RXS_DRIB_MII));
		w[`RXS_BIT_CRC] = !crc_good || rxer;
		w[`RXS_BIT_SUMMARY] = w[`RXS_BIT_RUNT] | w[`RXS_BIT_TOO_LONG]
			| w[`RXS_BIT_LATE_COL] | w[`RXS_BIT_CRC];
		w[`RXS_BIT_RSVD31] = 1'b0;
		w[`RXS_BIT_RSVD14] = 1'b0;
		w[`RXS_BIT_RSVD9:`RXS_BIT_RSVD8] = 2'b00;
		w[`RXS_BIT_RSVD0] = 1'b0;
		return w;
	endfunction : build_word

	// Status FIFO full at push time loses the word
	assign overrun = (state == st_wait) && data_load_done && stat_fifo_full
		&& !(word[`RXS_BIT_RUNT] && !pass_bad_frames);

	// Receive sequence, status hand-off and error flag
	always_comb
	begin
		next_state       = state;
		next_word        = word;
		next_rx_er_seen  = rx_er_seen;
		next_late_col    = late_col;
		next_stat_push   = 1'b0;
		next_stat_word   = stat_word;
		next_frame_drop  = 1'b0;
		next_stopped_irq = 1'b0;
		next_rx_halted   = rx_halted;
		case (state)
			st_idle:
			begin
				if (!receive_enable)
				begin
					next_state       = st_stop;
					next_stopped_irq = 1'b1;
					next_rx_halted   = 1'b1;
				end
				else if (start_ok)
				begin
					next_state      = st_recv;
					next_rx_er_seen = 1'b0;
					next_late_col   = 1'b0;
				end
			end
			st_recv:
			begin
				// receive error accumulated over the frame
				if (mii_rx_er)
					next_rx_er_seen = 1'b1;
				if (collision && byte_count >= `RXS_COLL_WINDOW)
					next_late_col = 1'b1;
				if (frame_end)
				begin
					next_state = st_wait;
					next_word  = build_word(byte_count, filter_fail, da_bcast, da_group,
						len_type, wdog_expired, rx_er_seen || mii_rx_er,
						late_col || (collision && byte_count >= `RXS_COLL_WINDOW),
						crc_ok, dribble_bits, speed_10m);
				end
			end
			st_wait:
			begin
				// status only after data is loaded
				if (data_load_done)
				begin
					next_state = st_idle;
					if (word[`RXS_BIT_RUNT] && !pass_bad_frames)
						next_frame_drop = 1'b1;
					else if (!stat_fifo_full)
					begin
						next_stat_push = 1'b1;
						next_stat_word = word;
					end
				end
			end
			st_stop:
			begin
				if (receive_enable)
				begin
					next_state     = st_idle;
					next_rx_halted = 1'b0;
				end
			end
			default:
			begin
				next_state = st_idle;
			end
		endcase
		// underruns and overrun set, set wins over clear
		// flag has no effect on the sequence
		next_error_flag = (host_data_rd && data_fifo_empty)
			|| (host_stat_rd && stat_fifo_empty) || overrun
			|| (receiver_error_flag && !rxe_clear);
	end

	// Sequence and output registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state               <= st_idle;
			word                <= `RXS_WORD_RESET;
			rx_er_seen          <= 1'b0;
			late_col            <= 1'b0;
			stat_push           <= 1'b0;
			stat_word           <= `RXS_WORD_RESET;
			frame_drop          <= 1'b0;
			receiver_error_flag <= 1'b0;
			receive_stopped_irq <= 1'b0;
			rx_halted           <= 1'b0;
		end
		else
		begin
			state               <= next_state;
			word                <= next_word;
			rx_er_seen          <= next_rx_er_seen;
			late_col            <= next_late_col;
			stat_push           <= next_stat_push;
			stat_word           <= next_stat_word;
			frame_drop          <= next_frame_drop;
			receiver_error_flag <= next_error_flag;
			receive_stopped_irq <= next_stopped_irq;
			rx_halted           <= next_rx_halted;
		end
	end

	// Checks on the status word and control
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_RSVD_ZERO: assert property (
		stat_push |-> (stat_word[31] == 1'b0 && stat_word[14] == 1'b0
			&& stat_word[9:8] == 2'b00 && stat_word[0] == 1'b0))
		else $error("reserved status bit set");

	AST_LEN_COUNT: assert property (
		stat_push |-> stat_word[29:16] == byte_count)
		else $error("status length differs from byte count");

	AST_SUMMARY: assert property (
		stat_push |-> stat_word[15] == (stat_word[11] | stat_word[7]
			| stat_word[6] | stat_word[1]))
		else $error("summary error bit wrong");

	AST_BCAST: assert property (
		stat_push |-> stat_word[13] == da_bcast)
		else $error("broadcast bit wrong");

	AST_RUNT_DROP: assert property (
		(state == st_wait && data_load_done && word[11] && !pass_bad_frames)
			|=> frame_drop && !stat_push)
		else $error("runt forwarded without pass-bad");

	AST_TOO_LONG: assert property (
		stat_push |-> stat_word[7] == (byte_count > 14'h05EE))
		else $error("too-long bit wrong");

	AST_FTYPE_SHORT: assert property (
		(stat_push && byte_count < 14'h000E) |-> !stat_word[5])
		else $error("frame type set on short frame");

	AST_DRIB_LATE: assert property (
		(stat_push && stat_word[6]) |-> !stat_word[2])
		else $error("dribble set with late collision");

	AST_STOP_PULSE: assert property (
		(state == st_idle && !receive_enable)
			|=> receive_stopped_irq && rx_halted ##1 !receive_stopped_irq)
		else $error("stop pulse missing or long");

	AST_UNDERRUN: assert property (
		(host_data_rd && data_fifo_empty) || (host_stat_rd && stat_fifo_empty)
			|=> receiver_error_flag)
		else $error("underrun did not set error flag");

	AST_KEEP_RX: assert property (
		(receiver_error_flag && start_ok) |=> state == st_recv)
		else $error("error flag blocked reception");

	AST_AFTER_DATA: assert property (
		stat_push |-> $past(data_load_done) && $past(state) == st_wait)
		else $error("status pushed before data loaded");

	COV_PUSH: cover property (stat_push && stat_word[15]);
	COV_DROP: cover property (frame_drop);
	COV_STOP: cover property (receive_stopped_irq ##[1:20] !rx_halted);
	COV_OVERRUN: cover property (overrun);

endmodule : rx_status_ctrl

// ==== rx_host_model.sv ====
// Host side model: status FIFO fill level and its flags.
// Assumes host read and flush pulses come from the bench on clk.
`timescale 1ns/100ps

module rx_host_model
#(
	parameter int DEPTH = 4
)
(
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic stat_push,
	input  wire logic do_rd,
	input  wire logic do_flush,
	output logic      stat_fifo_full,
	output logic      stat_fifo_empty,
	output logic      data_fifo_empty
);
	int count;

	// Flags from fill level; data entries track status entries
	assign stat_fifo_full  = (count == DEPTH);
	assign stat_fifo_empty = (count == 0);
	assign data_fifo_empty = (count == 0);

	// Fill level: pushes in, reads out, flush empties
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			count <= 0;
		else if (do_flush)
			count <= 0;
		else if (stat_push && !stat_fifo_full)
			count <= count + 1;
		else if (do_rd && count > 0)
			count <= count - 1;
	end
endmodule : rx_host_model

// ==== rx_status_ctrl_bench.sv ====
// Self-checking bench for rx_status_ctrl with the host FIFO model.
// Assumes design files and rx_host_model are compiled first.
`timescale 1ns/100ps

module rx_status_ctrl_bench;
	logic        clk, nrst, receive_enable, pass_bad_frames, speed_10m;
	logic        frame_start, byte_valid, mii_rx_er, collision, frame_end, crc_ok;
	logic [7:0]  byte_data;
	logic [2:0]  dribble_bits;
	logic        filter_fail, data_load_done, host_data_rd, host_stat_rd, rxe_clear, flush;
	logic        stat_fifo_full, stat_fifo_empty, data_fifo_empty;
	logic        stat_push, frame_drop, receiver_error_flag, receive_stopped_irq, rx_halted;
	logic [31:0] stat_word;
	int          mismatches, n_tests, seed, k;
	bit          auto_rd;

	rx_status_ctrl u_dut (.clk, .nrst, .receive_enable, .pass_bad_frames, .speed_10m,
		.frame_start, .byte_valid, .byte_data, .mii_rx_er, .collision, .frame_end,
		.crc_ok, .dribble_bits, .filter_fail, .data_load_done, .stat_fifo_full,
		.host_data_rd, .data_fifo_empty, .host_stat_rd, .stat_fifo_empty, .rxe_clear,
		.stat_push, .stat_word, .frame_drop, .receiver_error_flag,
		.receive_stopped_irq, .rx_halted);

	rx_host_model u_host (.clk, .nrst, .stat_push, .do_rd(host_stat_rd), .do_flush(flush),
		.stat_fifo_full, .stat_fifo_empty, .data_fifo_empty);

	// Clock, 4 ns period
	initial
	begin
		clk = 0;
		forever #2 clk = ~clk;
	end

	// Expected status word for one frame
	function automatic logic [31:0] expect_word(int n, int da, logic [15:0] lt, bit er,
		bit lc, bit crc, logic [2:0] dr, bit ff);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[30] = ff;
		w[29:16] = n[13:0];
		w[13] = (da == 2);
		w[12] = (lt <= 16'h05DC) && n >= 18 && lt != n - 18 && !(n == 64 && lt < 46);
		w[11] = (n < 64);
		w[10] = (da == 1);
		w[7] = (n > 1518);
		w[6] = lc && n > 64;
		w[5] = (lt > 16'h05DC) && n >= 14;
		w[4] = (n > 2048);
		w[3] = er;
		w[2] = (speed_10m ? dr >= 3'h3 : dr == 3'h4) && !w[6];
		w[1] = !crc || er;
		w[15] = w[11] | w[7] | w[6] | w[1];
		return w;
	endfunction : expect_word

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	task close_out;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// One frame: start, bytes, end, load done, then push or drop
	task automatic send_frame(int n, int da, logic [15:0] lt, bit er, bit lc, bit crc,
		logic [2:0] dr, bit ff);
		logic [31:0] exp;
		logic [7:0]  b;
		bit          full;
		@(negedge clk);
		exp = expect_word(n, da, lt, er, lc, crc, dr, ff);
		frame_start = 1;
		@(negedge clk);
		frame_start = 0;
		for (int i = 0; i < n; i++)
		begin
			b = $random(seed);
			if ((i < 6 && da == 2) || (i == 1 && da == 1))
				b = (da == 2) ? 8'hFF : 8'h00;
			if (i == 0 && da != 2)
				b = (da == 1) ? (b | 8'h01) : (b & 8'hFE);
			if (i == 12 || i == 13)
				b = (i == 12) ? lt[15:8] : lt[7:0];
			byte_data = b;
			byte_valid = 1;
			mii_rx_er = er && i == 15;
			collision = lc && i >= 64;
			@(negedge clk);
		end
		byte_valid = 0;
		{frame_end, crc_ok, dribble_bits, filter_fail} = {1'b1, crc, dr, ff};
		@(negedge clk);
		frame_end = 0;
		collision = 0;
		chk_bit(stat_push, 0);
		// Full status FIFO at hand-off loses the word
		full = stat_fifo_full;
		data_load_done = 1;
		@(negedge clk);
		data_load_done = 0;
		if (n < 64 && !pass_bad_frames)
			chk_bit(frame_drop, 1);
		else
		begin
			chk_bit(stat_push, !full);
			if (!full)
				chk_word(stat_word, exp);
		end
		if (stat_push && auto_rd)
		begin
			@(negedge clk);
			{host_stat_rd, host_data_rd} = 2'h3;
			@(negedge clk);
			{host_stat_rd, host_data_rd} = 2'h0;
		end
	endtask : send_frame

	task err_chk(input logic e);
		@(posedge clk);
		#1 chk_bit(receiver_error_flag, e);
	endtask : err_chk

	task clr_err;
		@(negedge clk) rxe_clear = 1;
		@(negedge clk) rxe_clear = 0;
		err_chk(0);
	endtask : clr_err

	// Hang guard
	initial
	begin
		#120000;
		mismatches++;
		close_out();
	end

	// Main sequence
	initial
	begin
		{nrst, pass_bad_frames, speed_10m, frame_start, byte_valid, byte_data} = 0;
		{mii_rx_er, collision, frame_end, crc_ok, dribble_bits, filter_fail} = 0;
		{data_load_done, host_data_rd, host_stat_rd, rxe_clear, flush} = 0;
		{mismatches, n_tests} = 0;
		receive_enable = 1;
		auto_rd = 1;
		seed = 68898;
		repeat (10) @(posedge clk);
		@(negedge clk) nrst = 1;
		// Corner frames
		send_frame(63, 2, 16'h0800, 0, 0, 1, 3'h0, 0);
		@(negedge clk) pass_bad_frames = 1;
		send_frame(20, 1, 16'h0002, 0, 0, 1, 3'h0, 1);
		send_frame(64, 0, 16'd46, 0, 0, 1, 3'h0, 0);
		send_frame(64, 0, 16'd100, 0, 0, 1, 3'h0, 0);
		send_frame(1518, 2, 16'h05DC, 0, 0, 1, 3'h0, 0);
		send_frame(1519, 1, 16'h05DD, 0, 0, 1, 3'h0, 0);
		send_frame(2048, 0, 16'h0800, 1, 1, 0, 3'h4, 1);
		send_frame(2049, 0, 16'h0800, 0, 0, 1, 3'h3, 0);
		@(negedge clk) speed_10m = 1;
		send_frame(200, 0, 16'h0800, 0, 0, 1, 3'h3, 0);
		// Random frames
		for (int f = 0; f < 24; f++)
		begin
			@(negedge clk);
			speed_10m = $random(seed);
			pass_bad_frames = $random(seed);
			k = 20 + {$random(seed)} % 300;
			send_frame(k, {$random(seed)} % 3, ($random(seed) & 1) ? k - 18 : $random(seed),
				$random(seed), (($random(seed) & 3) == 0), $random(seed), $random(seed),
				$random(seed));
		end
		@(negedge clk) receive_enable = 0;
		k = 0;
		repeat (6)
		begin
			@(posedge clk);
			#1 k += receive_stopped_irq;
		end
		chk_bit(k == 1, 1);
		chk_bit(rx_halted, 1);
		@(negedge clk) flush = 1;
		@(negedge clk) flush = 0;
		receive_enable = 1;
		repeat (3) @(posedge clk);
		#1 chk_bit(rx_halted, 0);
		@(negedge clk) host_stat_rd = 1;
		@(negedge clk) host_stat_rd = 0;
		err_chk(1);
		send_frame(80, 0, 16'h0800, 0, 0, 1, 3'h0, 0);
		clr_err();
		auto_rd = 0;
		repeat (5) send_frame(80, 1, 16'h0800, 0, 0, 1, 3'h0, 0);
		err_chk(1);
		@(negedge clk) flush = 1;
		@(negedge clk) flush = 0;
		auto_rd = 1;
		clr_err();
		@(negedge clk) host_data_rd = 1;
		@(negedge clk) host_data_rd = 0;
		err_chk(1);
		@(negedge clk) nrst = 0;
		#1 chk_bit(receiver_error_flag, 0);
		repeat (3) @(negedge clk);
		nrst = 1;
		send_frame(90, 2, 16'd72, 0, 0, 1, 3'h0, 0);
		close_out();
	end
endmodule : rx_status_ctrl_bench
